// [dv/pst_mem_model.sv]
// program memory model on the memory port
// assumes mem_req is held until mem_ack
`timescale 1ns/100ps
module pst_mem_model
  import pst_pkg::*;
(
  // clock and reset
  input wire logic               core_clk,
  input wire logic               reset,
  // memory port
  input wire logic               mem_req,
  input wire logic               mem_we,
  input wire logic               mem_high,
  input wire logic               mem_cfg,
  input wire logic [PADDR_W-1:0] mem_addr,
  input wire logic [DWORD_W-1:0] mem_wdata,
  input wire logic [1:0]         mem_be,
  output logic     [PWORD_W-1:0] mem_rdata,
  output logic                   mem_ack,
  // wait cycles before ack
  input wire logic [1:0]         lat
);
  logic [PWORD_W-1:0] m [32];
  logic [1:0]         n;
  logic [4:0]         i;
  assign i = {mem_cfg, mem_addr[3:0]};
  initial for (int k = 0; k < 32; k++) m[k] = 24'h408010 + {3{k[7:0]}};
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      n <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 24'h000000;
    end else if (mem_req && !mem_ack && n == lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= m[i];
      if (mem_we && mem_high && |mem_be) m[i][23:16] <= mem_wdata[7:0];
      if (mem_we && !mem_high && mem_be[0]) m[i][7:0] <= mem_wdata[7:0];
      if (mem_we && !mem_high && mem_be[1]) m[i][15:8] <= mem_wdata[15:8];
    end else begin
      mem_ack <= 1'b0;
      n <= (mem_req && !mem_ack) ? n + 2'h1 : 2'h0;
      // data lines not held outside an answer
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// [dv/pst_table_access_assertions.sv]
// port checks for the table access block
// assumes it is bound into pst_table_access
`timescale 1ns/100ps
module pst_chk
  import pst_pkg::*;
(
  // clock and reset
  input wire logic               core_clk,
  input wire logic               reset,
  // core port
  input wire logic               core_valid,
  input wire logic [1:0]         core_op,
  input wire logic               core_byte,
  input wire logic [15:0]        core_addr,
  input wire logic               core_done,
  input wire logic               core_refused,
  input wire logic [DWORD_W-1:0] core_rdata,
  // memory port
  input wire logic               mem_req,
  input wire logic               mem_we,
  input wire logic               mem_high,
  input wire logic [PADDR_W-1:0] mem_addr,
  input wire logic [PWORD_W-1:0] mem_rdata,
  input wire logic               mem_ack
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [PWORD_W-1:0] p_q;
  // word as taken at the ack edge
  always_ff @(posedge core_clk) if (mem_req && mem_ack) p_q <= mem_rdata;
  logic               rd_done;
  assign rd_done = core_done && core_valid;
  word_index_a: assert property (mem_req && core_valid |-> mem_addr[14:0] == core_addr[15:1])
    else $error("word index not taken from address bits 15:1");
  space_sel_a: assert property (mem_req && core_valid |-> mem_high == core_op[0])
    else $error("wrong program space for operation");
  write_dir_a: assert property (mem_req && core_valid |-> mem_we == core_op[1])
    else $error("memory direction differs from operation");
  refuse_quiet_a: assert property (core_refused |-> core_done && !mem_req)
    else $error("refused write touched memory");
  ack_done_a: assert property (mem_req && mem_ack |=> core_done && !mem_req)
    else $error("no completion one cycle after ack");
  low_word_a: assert property (rd_done && core_op == OP_READ_LOW && !core_byte
    |-> core_rdata == p_q[15:0]) else $error("low word read wrong");
  low_byte_a: assert property (rd_done && core_op == OP_READ_LOW && core_byte
    |-> core_rdata == {8'h00, core_addr[0] ? p_q[15:8] : p_q[7:0]})
    else $error("low byte read wrong");
  high_word_a: assert property (rd_done && core_op == OP_READ_HIGH && !core_byte
    |-> core_rdata == {8'h00, p_q[23:16]}) else $error("high word read wrong");
  phantom_zero_a: assert property (rd_done && core_op == OP_READ_HIGH && core_byte
    |-> core_rdata == (core_addr[0] ? 16'h0000 : {8'h00, p_q[23:16]}))
    else $error("high byte read wrong");
  cover property (core_done && core_refused);
  cover property (mem_req && mem_we && mem_ack);
  cover property (core_done && core_op == OP_READ_HIGH && core_byte && core_addr[0]);
endmodule
bind pst_table_access pst_chk pst_chk_inst (.core_clk(core_clk), .reset(reset),
  .core_valid(core_valid), .core_op(core_op), .core_byte(core_byte), .core_addr(core_addr),
  .core_done(core_done), .core_refused(core_refused), .core_rdata(core_rdata),
  .mem_req(mem_req), .mem_we(mem_we), .mem_high(mem_high), .mem_addr(mem_addr),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack));

// [dv/pst_table_access_tb.sv]
// self-checking bench for the table access block
// assumes pst_mem_model answers the memory port
`timescale 1ns/100ps
module pst_table_access_tb;
  import pst_pkg::*;
  logic        core_clk, reset, avs_read, avs_write, avs_waitrequest, core_valid, core_byte;
  logic        core_ready, core_done, core_refused, mem_req, mem_we, mem_high, mem_cfg, mem_ack;
  logic        cf;
  logic [1:0]  core_op, mem_be, lat;
  logic [3:0]  avs_address;
  logic [15:0] core_addr, core_wdata, core_rdata, mem_wdata, cr, ex;
  logic [22:0] mem_addr;
  logic [23:0] mem_rdata;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  cnt;
  int          mismatches, compares;
  pst_table_access pst_table_access_inst (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_valid(core_valid), .core_op(core_op),
    .core_byte(core_byte), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_ready(core_ready), .core_done(core_done), .core_refused(core_refused),
    .core_rdata(core_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_high(mem_high),
    .mem_cfg(mem_cfg), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  pst_mem_model pst_mem_model_inst (.core_clk(core_clk), .reset(reset), .mem_req(mem_req),
    .mem_we(mem_we), .mem_high(mem_high), .mem_cfg(mem_cfg), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .lat(lat));
  // ****
  // tasks
  // ****
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait, a hang ends the run
  task automatic wait_on(ref logic s, input logic v);
    int t;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (s !== v && t < 50);
    if (s !== v) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    wait_on(avs_waitrequest, 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic op(input logic [1:0] o, input logic b, input logic [15:0] a, d);
    @(posedge core_clk);
    core_valid <= 1'b1;
    core_op <= o;
    core_byte <= b;
    core_addr <= a;
    core_wdata <= d;
    wait_on(core_done, 1'b1);
    cr = core_rdata;
    cf = core_refused;
    core_valid <= 1'b0;
  endtask
  function automatic logic [15:0] fmt(input logic hi, b, sel, input logic [23:0] p);
    if (hi) return (b && sel) ? 16'h0000 : {8'h00, p[23:16]};
    if (b) return {8'h00, sel ? p[15:8] : p[7:0]};
    return p[15:0];
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ****
  // sequence
  // ****
  initial begin
    {reset, avs_read, avs_write, core_valid, core_byte} = 5'h10;
    {avs_address, avs_writedata, core_op, core_addr, core_wdata, lat} = '0;
    mismatches = 0;
    compares = 0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    for (int a = 0; a < 5; a++) begin
      bus(1'b0, (a == 4) ? 4'h2 : 4'(a * 4), 32'h0);
      check("reset reg", rd, 32'h0);
    end
    check("idle ready", core_ready, 1'b1);
    // every read form, both spaces, prompt and slow memory
    for (int s = 0; s < 32; s++) begin
      lat <= 2'(s);
      if (s % 16 == 0) begin
        bus(1'b1, REG_PAGE, {24'h0, s[4], 7'h00});
        bus(1'b0, REG_STATUS, 32'h0);
        check("cfg", rd[STAT_CFG_BIT], s[4]);
      end
      op({1'b0, s[2]}, s[1], {11'h4b3, s[3] ? 4'h5 : 4'ha, s[0]}, 16'h0);
      ex = fmt(s[2], s[1], s[0], 24'h408010 + {3{3'h0, s[4], s[3] ? 4'h5 : 4'ha}});
      check("read", cr, ex);
    end
    bus(1'b0, REG_RDATA, 32'h0);
    check("last read", rd, {16'h0, ex});
    bus(1'b1, REG_PAGE, 32'h0);
    op(OP_WRITE_LOW, 1'b0, 16'h0004, 16'hbeef);
    check("refused", cf, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    check("err", rd[STAT_ERR_BIT], 1'b1);
    bus(1'b1, REG_STATUS, 32'h2);
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    check("err clear", rd[STAT_ERR_BIT], 1'b0);
    cnt = rd[15:8];
    lat <= 2'h3;
    op(OP_WRITE_LOW, 1'b0, 16'h0004, 16'hbeef);
    check("accepted", cf, 1'b0);
    op(OP_WRITE_HIGH, 1'b1, 16'h0004, 16'h0077);
    op(OP_WRITE_HIGH, 1'b1, 16'h0005, 16'h0066);
    op(OP_WRITE_LOW, 1'b1, 16'h0007, 16'h0055);
    bus(1'b0, REG_STATUS, 32'h0);
    check("access count", rd[15:8], cnt + 8'h03);
    op(OP_READ_LOW, 1'b0, 16'h0004, 16'h0);
    check("low word back", cr, 16'hbeef);
    op(OP_READ_HIGH, 1'b0, 16'h0004, 16'h0);
    check("high byte back", cr, 16'h0077);
    op(OP_READ_LOW, 1'b0, 16'h0006, 16'h0);
    check("byte lane back", cr, 16'h5513);
    report_and_stop();
  end
endmodule

// [hw/pst_pkg.sv]
// package for the program space table access block
// assumes one 20 MHz clock and an asynchronous active-high reset
package pst_pkg;

  // ****************************************
  // table operations
  // ****************************************
  typedef enum logic [1:0] {
    OP_READ_LOW   = 2'b00,
    OP_READ_HIGH  = 2'b01,
    OP_WRITE_LOW  = 2'b10,
    OP_WRITE_HIGH = 2'b11
  } pst_op_t;

  typedef enum logic {
    ST_IDLE   = 1'b0,
    ST_ACCESS = 1'b1
  } pst_state_t;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [3:0] REG_PAGE   = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RDATA  = 4'hc;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned PAGE_CFG_BIT   = 7;
  localparam int unsigned CTRL_WEN_BIT   = 0;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_ERR_BIT   = 1;
  localparam int unsigned STAT_CFG_BIT   = 2;
  localparam int unsigned STAT_CNT_LSB   = 8;
  localparam logic [7:0]  PAGE_RESET     = 8'h00;
  localparam logic        CTRL_WEN_RESET = 1'b0;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned PWORD_W = 24;
  localparam int unsigned DWORD_W = 16;
  localparam int unsigned PADDR_W = 23;

endpackage

// [hw/pst_read_format.sv]
// read lane formatter: places a program word into a data word
// assumes purely combinational use inside the table access datapath
`timescale 1ns/100ps

module pst_read_format
  import pst_pkg::*;
(
  // selection
  input  wire logic                 read_high,
  input  wire logic                 byte_mode,
  input  wire logic                 byte_sel,
  // data
  input  wire logic [PWORD_W-1:0]   pword,
  output logic      [DWORD_W-1:0]   dword
);

  always_comb begin
    dword = 16'h0000;
    if (!read_high) begin
      if (!byte_mode) begin
        dword = pword[15:0];
      end else if (byte_sel) begin
        dword = {8'h00, pword[15:8]};
      end else begin
        dword = {8'h00, pword[7:0]};
      end
    end else begin
      // phantom byte is never backed by storage
      if (!byte_mode) begin
        dword = {8'h00, pword[23:16]};
      end else if (!byte_sel) begin
        dword = {8'h00, pword[23:16]};
      end else begin
        dword = 16'h0000;
      end
    end
  end

endmodule

// [hw/pst_table_access.sv]
// program space table access datapath with avalon-mm register slave
// assumes core and program memory run on core_clk; flash timing lives elsewhere
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps

module pst_table_access
  import pst_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // avalon-mm register slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // core table instruction port
  input  wire logic                 core_valid,
  input  wire logic [1:0]           core_op,
  input  wire logic                 core_byte,
  input  wire logic [15:0]          core_addr,
  input  wire logic [DWORD_W-1:0]   core_wdata,
  output logic                      core_ready,
  output logic                      core_done,
  output logic                      core_refused,
  output logic      [DWORD_W-1:0]   core_rdata,
  // program memory and flash write latch port
  output logic                      mem_req,
  output logic                      mem_we,
  output logic                      mem_high,
  output logic                      mem_cfg,
  output logic      [PADDR_W-1:0]   mem_addr,
  output logic      [DWORD_W-1:0]   mem_wdata,
  output logic      [1:0]           mem_be,
  input  wire logic [PWORD_W-1:0]   mem_rdata,
  input  wire logic                 mem_ack
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pst_state_t          st;
    logic                wait_n;
    logic [31:0]         rdata;
    logic [7:0]          page;
    logic                wen;
    logic                err;
    logic [7:0]          count;
    logic [DWORD_W-1:0]  last_rd;
    logic                ready;
    logic                done;
    logic                refused;
    logic [DWORD_W-1:0]  crdata;
    pst_op_t             op;
    logic                bmode;
    logic                bsel;
    logic                req;
    logic                we;
    logic                high;
    logic                cfg;
    logic [PADDR_W-1:0]  addr;
    logic [DWORD_W-1:0]  wdata;
    logic [1:0]          be;
  } pst_regs_t;

  pst_regs_t           s_q;
  pst_regs_t           s_d;
  logic [DWORD_W-1:0]  fmt_data;
  pst_op_t             new_op;

  // ****************************************
  // decode helpers
  // ****************************************
  // phantom byte: high space, byte form, select one; never backed by storage
  function automatic logic is_phantom(input logic [1:0] o, input logic b, input logic sel);
    return o[0] && b && sel;
  endfunction

  // top bit unused: page bit 7 leaves separately as mem_cfg
  function automatic logic [PADDR_W-1:0] word_index(input logic [7:0]  pg,
                                                    input logic [15:0] a);
    return {1'b0, pg[6:0], a[15:1]};
  endfunction

  function automatic logic [31:0] reg_read(input pst_regs_t s, input logic [3:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      REG_PAGE: v[7:0] = s.page;
      REG_CTRL: v[CTRL_WEN_BIT] = s.wen;
      REG_STATUS: begin
        v[STAT_BUSY_BIT] = (s.st == ST_ACCESS);
        v[STAT_ERR_BIT]  = s.err;
        v[STAT_CFG_BIT]  = s.page[PAGE_CFG_BIT];
        v[STAT_CNT_LSB +: 8] = s.count;
      end
      REG_RDATA: v[DWORD_W-1:0] = s.last_rd;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ****************************************
  // read formatting
  // ****************************************
  pst_read_format pst_read_format_inst (
    .read_high (s_q.op == OP_READ_HIGH),
    .byte_mode (s_q.bmode),
    .byte_sel  (s_q.bsel),
    .pword     (mem_rdata),
    .dword     (fmt_data)
  );

  assign new_op = pst_op_t'(core_op);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d         = s_q;
    s_d.done    = 1'b0;
    s_d.refused = 1'b0;
    s_d.wait_n  = 1'b0;

    // bus slave: one wait cycle, then answer; commit at the accepted edge
    if ((avs_read || avs_write) && !s_q.wait_n) begin
      s_d.wait_n = 1'b1;
      s_d.rdata  = reg_read(s_q, avs_address);
    end
    if (avs_write && s_q.wait_n) begin
      if (avs_address == REG_PAGE) begin
        s_d.page = avs_writedata[7:0];
      end
      if (avs_address == REG_CTRL) begin
        s_d.wen = avs_writedata[CTRL_WEN_BIT];
      end
      if (avs_address == REG_STATUS && avs_writedata[STAT_ERR_BIT]) begin
        s_d.err = 1'b0;
      end
    end

    unique case (s_q.st)
      ST_IDLE: begin
        // a request still held beside the done pulse is the one just finished
        if (core_valid && s_q.ready && !s_q.done) begin
          s_d.ready = 1'b0;
          s_d.op    = new_op;
          s_d.bmode = core_byte;
          s_d.bsel  = core_addr[0];
          s_d.high  = core_op[0];
          s_d.we    = core_op[1];
          s_d.cfg   = s_q.page[PAGE_CFG_BIT];
          // word index ignores address bit 0: two steps per word
          s_d.addr  = word_index(s_q.page, core_addr);
          s_d.wdata = 16'h0000;
          s_d.be    = 2'b00;
          unique case (new_op)
            OP_WRITE_LOW: begin
              if (!core_byte) begin
                s_d.wdata = core_wdata;
                s_d.be    = 2'b11;
              end else if (core_addr[0]) begin
                s_d.wdata = {core_wdata[7:0], 8'h00};
                s_d.be    = 2'b10;
              end else begin
                s_d.wdata = {8'h00, core_wdata[7:0]};
                s_d.be    = 2'b01;
              end
            end
            OP_WRITE_HIGH: begin
              // phantom byte write has no storage behind it
              if (!is_phantom(core_op, core_byte, core_addr[0])) begin
                s_d.wdata = {8'h00, core_wdata[7:0]};
                s_d.be    = 2'b01;
              end
            end
            OP_READ_LOW, OP_READ_HIGH: begin
              s_d.be = 2'b11;
            end
          endcase
          if (core_op[1] && (!s_q.wen || is_phantom(core_op, core_byte, core_addr[0]))) begin
            // refused or empty write: finish without touching flash
            s_d.done    = 1'b1;
            s_d.refused = !s_q.wen;
            // set wins over a software clear in the same cycle; a clear is kept otherwise
            s_d.err     = s_d.err || !s_q.wen;
            s_d.ready   = 1'b1;
          end else begin
            s_d.req = 1'b1;
            s_d.st  = ST_ACCESS;
          end
        end
      end
      ST_ACCESS: begin
        if (mem_ack) begin
          s_d.req   = 1'b0;
          s_d.we    = 1'b0;
          s_d.st    = ST_IDLE;
          s_d.done  = 1'b1;
          s_d.ready = 1'b1;
          s_d.count = s_q.count + 8'h01;
          if (!s_q.we) begin
            s_d.crdata  = fmt_data;
            s_d.last_rd = fmt_data;
          end
        end
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.op    <= OP_READ_LOW;
      s_q.page  <= PAGE_RESET;
      s_q.wen   <= CTRL_WEN_RESET;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = !s_q.wait_n;
  assign core_ready      = s_q.ready;
  assign core_done       = s_q.done;
  assign core_refused    = s_q.refused;
  assign core_rdata      = s_q.crdata;
  assign mem_req         = s_q.req;
  assign mem_we          = s_q.we;
  assign mem_high        = s_q.high;
  assign mem_cfg         = s_q.cfg;
  assign mem_addr        = s_q.addr;
  assign mem_wdata       = s_q.wdata;
  assign mem_be          = s_q.be;

endmodule
